// ### rtl/pmbs_pkg.sv
// Constants, timing figures and state type of the power mode sequencer
package pmbs_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_HOLD_NS = 2000;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STANDBY_IDLE_NS = 50000;
    localparam int STANDBY_IDLE_CYC = STANDBY_IDLE_NS / CLK_PERIOD_NS;
    localparam int WAKE_TICK_NS = 1000000;
    localparam int WAKE_TICK_CYC_DFLT = WAKE_TICK_NS / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;
    localparam int IDLE_CNT_W = 12;
    localparam int TICK_CNT_W = 16;
    localparam int GPIO_N_DFLT = 16;
    localparam int WAKE_W_DFLT = 16;
    localparam int BAUD_W = 12;
    localparam logic [BAUD_W-1:0] BAUD_SCALED_KBAUD = 12'h03E8;
    localparam logic [BAUD_W-1:0] BAUD_FULL_KBAUD = 12'h0BB8;
    localparam logic STRAP_PULLUP_LVL = 1'h1;
    localparam logic RESET_PIN_IDLE = 1'h1;
    localparam logic DSR_IDLE = 1'h1;
    localparam logic FLASH_1V8_LVL = 1'h1;
    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_BOOT = 6'h02,
        ST_ACTIVE = 6'h04,
        ST_STANDBY = 6'h08,
        ST_SLEEP = 6'h10,
        ST_STOP = 6'h20
    } pmbs_state_t;
endpackage

// ### rtl/pmbs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pmbs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ### rtl/pmbs_top.sv
// Power mode, reset and boot strap sequencer
`timescale 1ns/10ps
// What this block does
// RL1 - Supply rise or reset request reboots device
// RL2 - Low reset pin forces full hardware reset
// RL3 - Host drives reset pin open-drain only
// RL4 - Reboot command from host reboots device
// RL5 - Startup banner only once boot completes
// RL6 - Active and standby switch automatically
// RL7 - Standby returns to active at once
// RL8 - Clock scaling caps baud at 1 Mbaud
// RL9 - Sleep sends nothing on UART
// RL10 - DSR toggle enters or leaves sleep
// RL11 - Sleep only in station or radio off
// RL12 - Stop halts all; wake means full reboot
// RL13 - DSR toggle enters or leaves stop
// RL14 - Chosen GPIO toggles stop mode
// RL15 - Wake timer ends stop after delay
// RL16 - Factory strap low selects factory boot
// RL17 - All straps default high internally
// RL18 - Boot log strap low silences printout
// RL19 - Boot log pin becomes SPI select later
// RL20 - Flash strap high selects 1.8 V always
// RL21 - Host never pulls flash strap low
// RL22 - Flash pin becomes SPI data, detection starts
// RL23 - Straps latched once per boot
module pmbs_top import pmbs_pkg::*; #(
    parameter int GPIO_N = GPIO_N_DFLT,
    parameter int WAKE_W = WAKE_W_DFLT,
    parameter int WAKE_TICK_CYC = WAKE_TICK_CYC_DFLT
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic RESET_N_PIN,
    input wire logic DSR_PIN,
    input wire logic [GPIO_N-1:0] GPIO_PIN,
    input wire logic FACTORY_BOOT_STRAP,
    input wire logic BOOT_LOG_STRAP,
    input wire logic FLASH_VOLT_STRAP,
    input wire logic BOOT_DONE,
    input wire logic START_IN_CMD_MODE,
    input wire logic REBOOT_COMMAND,
    input wire logic SLEEP_CONTROL_ENABLE_CMD,
    input wire logic STOP_CONTROL_ENABLE_CMD,
    input wire logic STOP_CONFIG_CMD,
    input wire logic STOP_CFG_GPIO_EN,
    input wire logic [$clog2(GPIO_N)-1:0] STOP_CFG_GPIO_SEL,
    input wire logic STOP_CFG_TIMER_EN,
    input wire logic [WAKE_W-1:0] STOP_CFG_DELAY,
    input wire logic POWER_MANAGE_CMD,
    input wire logic AUTO_CLOCK_SCALING,
    input wire logic IF_ACTIVITY,
    input wire logic RADIO_ACTIVITY,
    input wire logic INCOMING_DATA,
    input wire logic RADIO_STA_OR_OFF,
    output logic CORE_RESET,
    output logic MODE_ACTIVE,
    output logic MODE_STANDBY,
    output logic MODE_SLEEP,
    output logic MODE_STOP,
    output logic KEEP_LINKS,
    output logic RAM_RETAIN,
    output logic UART_DELIVER_EN,
    output logic [BAUD_W-1:0] UART_BAUD_MAX_KBAUD,
    output logic STARTUP_BANNER,
    output logic BOOT_LOG_TX_EN,
    output logic FACTORY_BOOT,
    output logic FLASH_1V8_SEL,
    output logic PIN_RMII_CLK_MODE,
    output logic PIN_SPI_CS_MODE,
    output logic PIN_SPI_MISO_MODE,
    output logic IF_DETECT_EN
);
    localparam int SEL_W = $clog2(GPIO_N);
    localparam int SYNC_W = GPIO_N + 5;
    localparam logic [SYNC_W-1:0] SYNC_RST = {RESET_PIN_IDLE, DSR_IDLE,
        STRAP_PULLUP_LVL, STRAP_PULLUP_LVL, STRAP_PULLUP_LVL,
        {GPIO_N{1'h0}}};
    localparam logic [RST_CNT_W-1:0] RST_LAST =
        RST_CNT_W'(RESET_HOLD_CYC - 1);
    localparam logic [IDLE_CNT_W-1:0] IDLE_LAST =
        IDLE_CNT_W'(STANDBY_IDLE_CYC - 1);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(WAKE_TICK_CYC - 1);

    // Pin synchronisers
    logic [SYNC_W-1:0] pin_s;
    pmbs_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk(CLK),
        .srst(SRST),
        .d({RESET_N_PIN, DSR_PIN, FACTORY_BOOT_STRAP, BOOT_LOG_STRAP,
            FLASH_VOLT_STRAP, GPIO_PIN}),
        .q(pin_s)
    );

    wire rst_pin_n_s = pin_s[GPIO_N+4];
    wire dsr_s = pin_s[GPIO_N+3];
    wire factory_s = pin_s[GPIO_N+2];
    wire log_s = pin_s[GPIO_N+1];
    wire flashv_s = pin_s[GPIO_N];
    wire [GPIO_N-1:0] gpio_s = pin_s[GPIO_N-1:0];

    pmbs_state_t st_r, st_nxt;
    logic dsr_prev_r, stop_pin_prev_r;
    logic sleep_ctl_en_r, stop_ctl_en_r, stop_gpio_en_r, wake_en_r;
    logic auto_scale_r;
    logic [SEL_W-1:0] stop_gpio_sel_r;
    logic [WAKE_W-1:0] wake_delay_r, wake_cnt_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic [IDLE_CNT_W-1:0] idle_cnt_r;
    logic [TICK_CNT_W-1:0] tick_cnt_r;
    logic factory_lat_r, log_lat_r, flashv_lat_r;

    // Event decode
    wire dsr_toggle = dsr_s ^ dsr_prev_r;
    wire stop_pin_s = gpio_s[stop_gpio_sel_r];
    wire stop_pin_toggle = stop_pin_s ^ stop_pin_prev_r;
    wire running = (st_r == ST_ACTIVE) || (st_r == ST_STANDBY);
    wire booted = running || (st_r == ST_SLEEP);
    wire activity = IF_ACTIVITY | RADIO_ACTIVITY | INCOMING_DATA;
    wire idle_done = (idle_cnt_r == IDLE_LAST);
    wire tick_hit = (tick_cnt_r == TICK_LAST);
    wire sleep_go = running && dsr_toggle && sleep_ctl_en_r
        && RADIO_STA_OR_OFF; // [RL10] [RL11]
    wire sleep_leave = (st_r == ST_SLEEP) && dsr_toggle
        && sleep_ctl_en_r; // [RL10]
    wire stop_go = running && ((dsr_toggle && stop_ctl_en_r)
        || (stop_gpio_en_r && stop_pin_toggle)); // [RL13] [RL14]
    wire timer_wake = wake_en_r && tick_hit
        && (wake_cnt_r == wake_delay_r); // [RL15]
    wire stop_wake = (st_r == ST_STOP) && ((dsr_toggle && stop_ctl_en_r)
        || (stop_gpio_en_r && stop_pin_toggle) || timer_wake); // [RL13]
    wire reboot_req = !rst_pin_n_s
        || (REBOOT_COMMAND && st_r != ST_RESET)
        || stop_wake; // [RL2] [RL4] [RL12]
    wire rst_done = (rst_cnt_r == RST_LAST) && rst_pin_n_s;
    wire boot_exit = (st_r == ST_BOOT) && BOOT_DONE && !reboot_req;
    wire strap_latch = (st_r == ST_RESET) && rst_done; // [RL23]
    wire banner_cause = boot_exit && START_IN_CMD_MODE; // [RL5]
    wire cfg_ok = booted && !reboot_req;

    // Next state
    always_comb begin
        st_nxt = st_r;
        if (reboot_req) begin
            st_nxt = ST_RESET; // [RL1] [RL2] [RL4] [RL12]
        end else begin
            case (st_r)
                ST_RESET: begin
                    if (rst_done) begin
                        st_nxt = ST_BOOT;
                    end
                end
                ST_BOOT: begin
                    if (BOOT_DONE) begin
                        st_nxt = ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (sleep_go) begin
                        st_nxt = ST_SLEEP;
                    end else if (stop_go) begin
                        st_nxt = ST_STOP;
                    end else if (idle_done && !activity) begin
                        st_nxt = ST_STANDBY; // [RL6]
                    end
                end
                ST_STANDBY: begin
                    if (sleep_go) begin
                        st_nxt = ST_SLEEP;
                    end else if (stop_go) begin
                        st_nxt = ST_STOP;
                    end else if (activity) begin
                        st_nxt = ST_ACTIVE; // [RL6] [RL7]
                    end
                end
                ST_SLEEP: begin
                    if (sleep_leave) begin
                        st_nxt = ST_ACTIVE;
                    end
                end
                ST_STOP: begin
                    st_nxt = ST_STOP;
                end
                default: begin
                    st_nxt = ST_RESET;
                end
            endcase
        end
    end

    // State, edge memory and counters
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= ST_RESET; // [RL1]
            dsr_prev_r <= DSR_IDLE;
            stop_pin_prev_r <= 1'h0;
        end else begin
            st_r <= st_nxt;
            dsr_prev_r <= dsr_s;
            stop_pin_prev_r <= stop_pin_s;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || st_r != ST_RESET || !rst_pin_n_s) begin
            rst_cnt_r <= '0;
        end else if (!rst_done) begin
            rst_cnt_r <= rst_cnt_r + 1'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || st_r != ST_ACTIVE || activity) begin
            idle_cnt_r <= '0;
        end else if (!idle_done) begin
            idle_cnt_r <= idle_cnt_r + 1'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || st_r != ST_STOP || tick_hit) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || st_r != ST_STOP) begin
            wake_cnt_r <= '0;
        end else if (tick_hit && wake_cnt_r != wake_delay_r) begin
            wake_cnt_r <= wake_cnt_r + 1'h1; // [RL15]
        end
    end

    // Command-set configuration, lost on every reboot
    always_ff @(posedge CLK) begin
        if (SRST || st_r == ST_RESET) begin
            sleep_ctl_en_r <= 1'h0;
            stop_ctl_en_r <= 1'h0;
            stop_gpio_en_r <= 1'h0;
            stop_gpio_sel_r <= '0;
            wake_en_r <= 1'h0;
            wake_delay_r <= '0;
            auto_scale_r <= 1'h0;
        end else if (cfg_ok) begin
            if (SLEEP_CONTROL_ENABLE_CMD) begin
                sleep_ctl_en_r <= 1'h1; // [RL10]
                stop_ctl_en_r <= 1'h0;
            end else if (STOP_CONTROL_ENABLE_CMD) begin
                stop_ctl_en_r <= 1'h1; // [RL13]
                sleep_ctl_en_r <= 1'h0;
            end
            if (STOP_CONFIG_CMD) begin
                stop_gpio_en_r <= STOP_CFG_GPIO_EN; // [RL14]
                stop_gpio_sel_r <= STOP_CFG_GPIO_SEL;
                wake_en_r <= STOP_CFG_TIMER_EN; // [RL15]
                wake_delay_r <= STOP_CFG_DELAY;
            end
            if (POWER_MANAGE_CMD) begin
                auto_scale_r <= AUTO_CLOCK_SCALING;
            end
        end
    end

    // Strap capture at the end of each reset
    always_ff @(posedge CLK) begin
        if (SRST) begin
            factory_lat_r <= STRAP_PULLUP_LVL; // [RL17]
            log_lat_r <= STRAP_PULLUP_LVL;
            flashv_lat_r <= STRAP_PULLUP_LVL;
        end else if (strap_latch) begin
            factory_lat_r <= factory_s; // [RL16] [RL23]
            log_lat_r <= log_s; // [RL18] [RL23]
            flashv_lat_r <= flashv_s; // [RL23]
        end
    end

    // Registered outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CORE_RESET <= 1'h1;
            MODE_ACTIVE <= 1'h0;
            MODE_STANDBY <= 1'h0;
            MODE_SLEEP <= 1'h0;
            MODE_STOP <= 1'h0;
            KEEP_LINKS <= 1'h0;
            RAM_RETAIN <= 1'h0;
            UART_DELIVER_EN <= 1'h0;
            UART_BAUD_MAX_KBAUD <= BAUD_FULL_KBAUD;
            STARTUP_BANNER <= 1'h0;
            BOOT_LOG_TX_EN <= 1'h0;
            FACTORY_BOOT <= 1'h0;
            FLASH_1V8_SEL <= FLASH_1V8_LVL;
            PIN_RMII_CLK_MODE <= 1'h0;
            PIN_SPI_CS_MODE <= 1'h0;
            PIN_SPI_MISO_MODE <= 1'h0;
            IF_DETECT_EN <= 1'h0;
        end else begin
            CORE_RESET <= (st_nxt == ST_RESET); // [RL1] [RL2]
            MODE_ACTIVE <= (st_nxt == ST_ACTIVE);
            MODE_STANDBY <= (st_nxt == ST_STANDBY);
            MODE_SLEEP <= (st_nxt == ST_SLEEP);
            MODE_STOP <= (st_nxt == ST_STOP);
            KEEP_LINKS <= (st_nxt == ST_ACTIVE) || (st_nxt == ST_STANDBY)
                || (st_nxt == ST_SLEEP); // [RL7] [RL9] [RL12]
            RAM_RETAIN <= (st_nxt != ST_STOP)
                && (st_nxt != ST_RESET); // [RL12]
            UART_DELIVER_EN <= (st_nxt == ST_ACTIVE)
                || (st_nxt == ST_STANDBY); // [RL9]
            UART_BAUD_MAX_KBAUD <= auto_scale_r ? BAUD_SCALED_KBAUD
                : BAUD_FULL_KBAUD; // [RL8]
            STARTUP_BANNER <= banner_cause; // [RL5]
            BOOT_LOG_TX_EN <= (st_nxt == ST_BOOT)
                && (strap_latch ? log_s : log_lat_r); // [RL18]
            FACTORY_BOOT <= !factory_lat_r; // [RL16]
            FLASH_1V8_SEL <= (flashv_lat_r == FLASH_1V8_LVL); // [RL20]
            PIN_RMII_CLK_MODE <= booted; // [RL16]
            PIN_SPI_CS_MODE <= booted; // [RL19]
            PIN_SPI_MISO_MODE <= booted; // [RL22]
            IF_DETECT_EN <= running; // [RL22]
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_sleep_go;
        sleep_go && !reboot_req;
    endsequence

    sequence s_in_sleep;
        st_r == ST_SLEEP && MODE_SLEEP && !UART_DELIVER_EN;
    endsequence

    a_power_on_reset: assert property (disable iff (1'h0) // [RL1]
        SRST ##1 !SRST |-> CORE_RESET && st_r == ST_RESET)
        else $error("no reset state after power on");
    a_pin_reset_hold: assert property ( // [RL2]
        !rst_pin_n_s |=> CORE_RESET && !MODE_ACTIVE)
        else $error("reset pin low did not reset");
    a_reboot_cmd: assert property ( // [RL4]
        REBOOT_COMMAND && st_r != ST_RESET |=> st_r == ST_RESET)
        else $error("reboot command ignored");
    a_banner_after_boot: assert property ( // [RL5]
        STARTUP_BANNER |-> $past(banner_cause) && MODE_ACTIVE)
        else $error("banner not tied to boot completion");
    a_standby_wake: assert property ( // [RL7]
        st_r == ST_STANDBY && activity && !reboot_req && !sleep_go
        && !stop_go |=> MODE_ACTIVE)
        else $error("standby did not wake at once");
    a_baud_cap: assert property ( // [RL8]
        auto_scale_r |=> UART_BAUD_MAX_KBAUD == BAUD_SCALED_KBAUD)
        else $error("baud cap missing under scaling");
    a_sleep_entry: assert property ( // [RL10]
        s_sleep_go |=> s_in_sleep)
        else $error("dsr toggle did not enter sleep");
    a_sleep_radio_mode: assert property ( // [RL11]
        $rose(st_r == ST_SLEEP) |-> $past(RADIO_STA_OR_OFF))
        else $error("sleep entered in wrong radio mode");
    a_stop_wake_reboot: assert property ( // [RL12]
        stop_wake |=> CORE_RESET && !RAM_RETAIN ##1 st_r != ST_ACTIVE)
        else $error("stop wake without reboot");
    a_strap_stable: assert property ( // [RL23]
        st_r != ST_RESET |=> $stable(log_lat_r) && $stable(factory_lat_r))
        else $error("strap changed outside reset");
    a_flash_1v8: assert property ( // [RL20]
        FLASH_1V8_SEL)
        else $error("flash supply not 1.8 V");
endmodule

// ### tb/pmbs_host.sv
// Host model: open-drain reset, strap grounding, DSR and GPIO levels
`timescale 1ns/10ps
module pmbs_host (
    input wire logic rst_hold,
    input wire logic dsr_lvl,
    input wire logic [15:0] gpio_lvl,
    input wire logic factory_gnd,
    input wire logic log_gnd,
    output logic reset_n_pin,
    output logic dsr_pin,
    output logic [15:0] gpio_pin,
    output logic factory_strap,
    output logic log_strap,
    output logic flash_strap
);
    // Open drain: pull low or release to the pull-up
    assign reset_n_pin = rst_hold ? 1'h0 : 1'h1;
    // Straps float to their pull-up unless grounded
    assign factory_strap = factory_gnd ? 1'h0 : 1'h1;
    assign log_strap = log_gnd ? 1'h0 : 1'h1;
    // Flash strap is never pulled low
    assign flash_strap = 1'h1;
    assign dsr_pin = dsr_lvl;
    assign gpio_pin = gpio_lvl;
endmodule

// ### tb/pmbs_top_tb.sv
// Testbench for the power mode sequencer
`timescale 1ns/10ps
module pmbs_top_tb import pmbs_pkg::*;;
    localparam int TICK = 4;
    logic clk, srst, rst_hold, dsr_lvl, factory_gnd, log_gnd;
    logic [15:0] gpio_lvl, gpio, delay;
    logic reset_n, dsr, fac_s, log_s, fl_s;
    logic boot_done, cmd_mode, reboot, slp_en, stp_en, stp_cfg, gpio_en;
    logic [3:0] gpio_sel;
    logic tmr_en, pwr_cmd, scaling, if_act, radio_act, inc_data, sta_ok;
    logic core_reset, m_act, m_stb, m_slp, m_stp, keep, ram, deliver;
    logic [11:0] baud;
    logic banner, log_en, factory, fl18, rmii, cs, miso, det;
    int err_count = 0;
    int compares = 0;

    pmbs_host u_host (.rst_hold(rst_hold), .dsr_lvl(dsr_lvl),
        .gpio_lvl(gpio_lvl), .factory_gnd(factory_gnd), .log_gnd(log_gnd),
        .reset_n_pin(reset_n), .dsr_pin(dsr), .gpio_pin(gpio),
        .factory_strap(fac_s), .log_strap(log_s), .flash_strap(fl_s));

    pmbs_top #(.WAKE_TICK_CYC(TICK)) u_dut (.CLK(clk), .SRST(srst),
        .RESET_N_PIN(reset_n), .DSR_PIN(dsr), .GPIO_PIN(gpio),
        .FACTORY_BOOT_STRAP(fac_s), .BOOT_LOG_STRAP(log_s),
        .FLASH_VOLT_STRAP(fl_s), .BOOT_DONE(boot_done),
        .START_IN_CMD_MODE(cmd_mode), .REBOOT_COMMAND(reboot),
        .SLEEP_CONTROL_ENABLE_CMD(slp_en),
        .STOP_CONTROL_ENABLE_CMD(stp_en), .STOP_CONFIG_CMD(stp_cfg),
        .STOP_CFG_GPIO_EN(gpio_en), .STOP_CFG_GPIO_SEL(gpio_sel),
        .STOP_CFG_TIMER_EN(tmr_en), .STOP_CFG_DELAY(delay),
        .POWER_MANAGE_CMD(pwr_cmd), .AUTO_CLOCK_SCALING(scaling),
        .IF_ACTIVITY(if_act), .RADIO_ACTIVITY(radio_act),
        .INCOMING_DATA(inc_data), .RADIO_STA_OR_OFF(sta_ok),
        .CORE_RESET(core_reset), .MODE_ACTIVE(m_act),
        .MODE_STANDBY(m_stb), .MODE_SLEEP(m_slp), .MODE_STOP(m_stp),
        .KEEP_LINKS(keep), .RAM_RETAIN(ram), .UART_DELIVER_EN(deliver),
        .UART_BAUD_MAX_KBAUD(baud), .STARTUP_BANNER(banner),
        .BOOT_LOG_TX_EN(log_en), .FACTORY_BOOT(factory),
        .FLASH_1V8_SEL(fl18), .PIN_RMII_CLK_MODE(rmii),
        .PIN_SPI_CS_MODE(cs), .PIN_SPI_MISO_MODE(miso),
        .IF_DETECT_EN(det));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
        input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle command pulse: 0 reboot, 1 power, 2 sleep, 3 stop, 4 cfg
    task automatic cmd(input int k);
        @(posedge clk);
        reboot <= (k == 0);
        pwr_cmd <= (k == 1);
        slp_en <= (k == 2);
        stp_en <= (k == 3);
        stp_cfg <= (k == 4);
        @(posedge clk);
        {reboot, pwr_cmd, slp_en, stp_en, stp_cfg} <= 5'h00;
        #1;
    endtask

    // Toggle DSR (g < 0) or a GPIO, then let sync and state settle
    task automatic tog(input int g);
        @(posedge clk);
        if (g < 0) begin
            dsr_lvl <= ~dsr_lvl;
        end else begin
            gpio_lvl[g] <= ~gpio_lvl[g];
        end
        cyc(4);
    endtask

    task automatic boot(input logic exp_log, input logic exp_fac);
        @(posedge clk) boot_done <= 1'h0;
        cyc(110);
        chk(core_reset, 12'h000, "still in reset");
        chk(m_act, 12'h000, "active before boot done");
        chk(log_en, exp_log, "boot log enable");
        chk(factory, exp_fac, "factory boot");
        chk(fl18, 12'h001, "flash supply not 1.8 V");
        @(posedge clk) boot_done <= 1'h1;
        cyc(1);
        chk(m_act, 12'h001, "not active after boot");
        chk(banner, cmd_mode, "banner at boot end");
        chk(baud, BAUD_FULL_KBAUD, "config kept over reboot");
        cyc(1);
        chk(banner, 12'h000, "banner too long");
        chk(log_en, 12'h000, "log after boot");
        chk({rmii, cs, miso, det}, 12'h00F, "pin reuse");
    endtask

    initial begin
        srst = 1'h1;
        {rst_hold, factory_gnd, log_gnd, boot_done, reboot} = 5'h00;
        {slp_en, stp_en, stp_cfg, tmr_en, pwr_cmd, inc_data} = 6'h00;
        {radio_act, if_act, dsr_lvl, cmd_mode, sta_ok} = 5'h1F;
        {scaling, gpio_en} = 2'h3;
        gpio_lvl = 16'h0000;
        gpio_sel = 4'h5;
        delay = 16'h0003;
        cyc(6);
        chk(core_reset, 12'h001, "reset not entered");
        chk(baud, BAUD_FULL_KBAUD, "reset baud");
        chk(fl18, 12'h001, "flash voltage");
        @(posedge clk) srst <= 1'h0;
        boot(1'h1, 1'h0);
        @(posedge clk);
        factory_gnd <= 1'h1;
        log_gnd <= 1'h1;
        cyc(5);
        chk(factory, 12'h000, "strap relatched");
        cmd(1);
        cyc(1);
        chk(baud, BAUD_SCALED_KBAUD, "scaled baud");
        @(posedge clk) {if_act, radio_act} <= 2'h0;
        cyc(STANDBY_IDLE_CYC - 10);
        chk(m_act, 12'h001, "standby too early");
        cyc(15);
        chk(m_stb, 12'h001, "no standby");
        chk({keep, deliver}, 12'h003, "standby links");
        @(posedge clk) inc_data <= 1'h1;
        cyc(1);
        chk(m_act, 12'h001, "standby wake slow");
        cmd(2);
        @(posedge clk) sta_ok <= 1'h0;
        tog(-1);
        chk(m_slp, 12'h000, "sleep in wrong radio mode");
        @(posedge clk) sta_ok <= 1'h1;
        tog(-1);
        chk(m_slp, 12'h001, "no sleep");
        chk({keep, deliver}, 12'h002, "sleep uart");
        tog(-1);
        chk({m_slp, deliver}, 12'h001, "sleep not left");
        cmd(3);
        tog(-1);
        chk(m_stp, 12'h001, "no stop");
        chk({keep, ram}, 12'h000, "stop retains");
        tog(-1);
        chk(core_reset, 12'h001, "stop wake no reboot");
        boot(1'h0, 1'h1);
        @(posedge clk);
        factory_gnd <= 1'h0;
        log_gnd <= 1'h0;
        cmd(0);
        chk({core_reset, ram}, 12'h002, "reboot command");
        boot(1'h1, 1'h0);
        cmd(4);
        tog(5);
        chk(m_stp, 12'h001, "gpio stop");
        tog(5);
        chk(core_reset, 12'h001, "gpio wake");
        boot(1'h1, 1'h0);
        @(posedge clk) tmr_en <= 1'h1;
        cmd(4);
        cmd(3);
        tog(-1);
        cyc(2 * TICK - 2);
        chk(m_stp, 12'h001, "timer wake early");
        cyc(5 * TICK + 4);
        chk(core_reset, 12'h001, "timer wake missing");
        boot(1'h1, 1'h0);
        @(posedge clk) rst_hold <= 1'h1;
        cmd_mode <= 1'h0;
        cyc(4);
        chk(core_reset, 12'h001, "pin reset");
        cyc(100);
        chk(core_reset, 12'h001, "pin reset held");
        @(posedge clk) rst_hold <= 1'h0;
        boot(1'h1, 1'h0);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule
